// *** design/logic_fn_map.vh ***
`ifndef LOGIC_FN_MAP_VH
`define LOGIC_FN_MAP_VH

// Register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_STATUS 8'h08

// Control register bits (write only, self clearing)
`define CTRL_START 0
`define CTRL_STOP 1

// Configuration register fields
`define CFG_ACT_LSB 0
`define CFG_ACT_MSB 3
`define CFG_IN1_LSB 4
`define CFG_IN1_MSB 9
`define CFG_IN2_LSB 10
`define CFG_IN2_MSB 15
`define CFG_OUT_LSB 16
`define CFG_OUT_MSB 19
`define CFG_RUN_ONCE 20
`define CFG_RESET 21'h010100

// Source selector: bit 5 picks memory bit over output, bit 4 set means no source
`define SEL_KIND 5
`define SEL_NONE 4

// Status register bits
`define ST_STATE_MSB 2
`define ST_ERROR 3
`define ST_REFUSED 4
`define ST_OUT_OBS 5
`define ST_FIRED 6
`define ST_PENDING 7

// Action codes
`define ACT_NONE 4'h0
`define ACT_FOLLOW 4'h1
`define ACT_NFOLLOW 4'h2
`define ACT_PULSE_ON 4'h3
`define ACT_NPULSE_ON 4'h4
`define ACT_PULSE_OFF 4'h5
`define ACT_NPULSE_OFF 4'h6
`define ACT_OR 4'h7
`define ACT_AND 4'h8
`define ACT_NOR 4'h9
`define ACT_NAND 4'ha
`define ACT_XOR 4'hb

// Timing
`define CLK_HZ 100000000
`define TICK_HZ 1000
`define RESTORE_TIME_S 30
`define TICK_CYCLES (`CLK_HZ / `TICK_HZ)
`define RESTORE_TICKS (`RESTORE_TIME_S * `TICK_HZ)
`define SETTLE_CYCLES 3'h4

`endif

// *** design/restore_timer.v ***
// Counts a restore delay while run is high; any drop of run starts over.
module restore_timer #(
	parameter TICK_CYCLES = 100000,
	parameter RESTORE_TICKS = 30000
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Control
	input wire run,
	output reg expired
);
	reg [16:0] pre_q;
	reg [15:0] ticks_q;
	wire tick;

	// Millisecond enable keeps the long count in two short counters
	assign tick = (pre_q == TICK_CYCLES - 1);

	always @(posedge clk) begin
		if (srst || !run) begin
			pre_q <= 17'h00000;
			ticks_q <= 16'h0000;
			expired <= 1'b0;
		end else if (!expired) begin
			if (tick) begin
				pre_q <= 17'h00000;
				ticks_q <= ticks_q + 16'h0001;
				if (ticks_q == RESTORE_TICKS - 1)
					expired <= 1'b1;
			end else begin
				pre_q <= pre_q + 17'h00001;
			end
		end
	end
endmodule

// *** design/logic_fn.v ***
// Our own choices: the register offsets and the strobed register port.
`include "logic_fn_map.vh"

// Functional notes
// - Normal mode is default; a running normal-mode function restarts after a system restart.
// - Run-once mode acts a single time, then idles until stopped and started.
// - Eleven action codes select how the inputs combine into the output.
// - Follow drives the output equal to input one, re-evaluated continuously.
// - An output altered from outside is restored after 30 seconds.
// - The restore delay applies only to changes this function did not make.
// - Inverted follow drives the complement of input one, with delayed restore.
// - Pulse-on sets the output on at an off-to-on edge of input one.
// - Inverted pulse-on sets the output off at an off-to-on edge.
// - Pulse-off sets the output on at an on-to-off edge of input one.
// - Inverted pulse-off sets the output off at an on-to-off edge.
// - After a pulse action fires, the output is not touched again until a stop and start, or a system restart in normal mode, rearms it.
// - OR drives on when either input is on.
// - AND drives on only when both inputs are on.
// - NOR drives on only when both inputs are off.
// - NAND drives off only when both inputs are on.
// - XOR drives on when exactly one input is on.
// - OR and NOR restore their result after an outside change.
// - An invalid input one at start raises an error and suspends.
// - Input two is used only by two-input actions; sources are outputs or memory bits.
// - The output selector names the programmable output being driven.
// - Configuration writes while running are refused and only viewable.
module logic_fn #(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter RESTORE_TICKS = `RESTORE_TICKS
) (
	// Clock and reset
	input wire clk,
	input wire srst,
	// Register port
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	// Observed states of programmable outputs and memory bits
	input wire [15:0] pgm_in,
	input wire [15:0] mem_in,
	// System restart event
	input wire sys_restart,
	// Output drive command
	output reg pgm_wr,
	output reg [3:0] pgm_wr_idx,
	output reg pgm_wr_val
);
	localparam S_IDLE = 3'h0;
	localparam S_RUN = 3'h1;
	localparam S_DONE = 3'h2;
	localparam S_ERR = 3'h3;

	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [20:0] cfg_q;
	reg refused_q;
	reg error_q;
	reg fired_q;
	reg own_q;
	reg last_q;
	reg prev_in1_q;
	reg [2:0] settle_q;
	reg [15:0] pgm_s1_q;
	reg [15:0] pgm_s2_q;
	reg [15:0] mem_s1_q;
	reg [15:0] mem_s2_q;
	reg rst_s1_q;
	reg rst_s2_q;
	reg rst_s3_q;

	wire [3:0] act;
	wire [5:0] sel1;
	wire [5:0] sel2;
	wire [3:0] out_idx;
	wire run_once;
	wire in1;
	wire in2;
	wire in1_ok;
	wire obs;
	wire restart_evt;
	wire start_req;
	wire stop_req;
	wire cfg_wr;
	wire busy;
	wire follow_type;
	wire pulse_type;
	wire edge_hit;
	wire mismatch;
	wire expired;
	reg res;
	reg pulse_val;
	reg do_wr;
	reg wr_val;

	assign act = cfg_q[`CFG_ACT_MSB:`CFG_ACT_LSB];
	assign sel1 = cfg_q[`CFG_IN1_MSB:`CFG_IN1_LSB];
	assign sel2 = cfg_q[`CFG_IN2_MSB:`CFG_IN2_LSB];
	assign out_idx = cfg_q[`CFG_OUT_MSB:`CFG_OUT_LSB];
	assign run_once = cfg_q[`CFG_RUN_ONCE];

	// Outside states come from another part of the controller; synchronise them
	always @(posedge clk) begin
		if (srst) begin
			pgm_s1_q <= 16'h0000;
			pgm_s2_q <= 16'h0000;
			mem_s1_q <= 16'h0000;
			mem_s2_q <= 16'h0000;
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
			rst_s3_q <= 1'b0;
		end else begin
			pgm_s1_q <= pgm_in;
			pgm_s2_q <= pgm_s1_q;
			mem_s1_q <= mem_in;
			mem_s2_q <= mem_s1_q;
			rst_s1_q <= sys_restart;
			rst_s2_q <= rst_s1_q;
			rst_s3_q <= rst_s2_q;
		end
	end

	// Only the rising edge counts, so a held restart level re-arms once
	assign restart_evt = rst_s2_q && !rst_s3_q;

	// Each input reads an output or a memory bit; no source reads as off
	assign in1 = sel1[`SEL_NONE] ? 1'b0 :
		(sel1[`SEL_KIND] ? mem_s2_q[sel1[3:0]] : pgm_s2_q[sel1[3:0]]);
	assign in2 = sel2[`SEL_NONE] ? 1'b0 :
		(sel2[`SEL_KIND] ? mem_s2_q[sel2[3:0]] : pgm_s2_q[sel2[3:0]]);
	assign in1_ok = !sel1[`SEL_NONE];
	assign obs = pgm_s2_q[out_idx];

	assign start_req = wr && (addr == `REG_CTRL) && wdata[`CTRL_START];
	assign stop_req = wr && (addr == `REG_CTRL) && wdata[`CTRL_STOP];
	assign cfg_wr = wr && (addr == `REG_CFG);
	assign busy = (state_q == S_RUN) || (state_q == S_DONE);

	// Eleven actions; codes above the last one act as none
	assign follow_type = (act == `ACT_FOLLOW) || (act == `ACT_NFOLLOW) ||
		((act >= `ACT_OR) && (act <= `ACT_XOR));
	assign pulse_type = (act >= `ACT_PULSE_ON) && (act <= `ACT_NPULSE_OFF);

	always @* begin
		res = 1'b0;
		case (act)
			`ACT_FOLLOW: res = in1;
			`ACT_NFOLLOW: res = !in1;
			`ACT_OR: res = in1 | in2;
			`ACT_AND: res = in1 & in2;
			`ACT_NOR: res = !(in1 | in2);
			`ACT_NAND: res = !(in1 & in2);
			`ACT_XOR: res = in1 ^ in2;
			default: res = 1'b0;
		endcase
	end

	// Pulse actions react to one edge of input one and one value each
	assign edge_hit = ((act == `ACT_PULSE_ON) && in1 && !prev_in1_q) ||
		((act == `ACT_NPULSE_ON) && in1 && !prev_in1_q) ||
		((act == `ACT_PULSE_OFF) && !in1 && prev_in1_q) ||
		((act == `ACT_NPULSE_OFF) && !in1 && prev_in1_q);

	always @* begin
		pulse_val = 1'b0;
		case (act)
			`ACT_PULSE_ON: pulse_val = 1'b1;
			`ACT_PULSE_OFF: pulse_val = 1'b1;
			default: pulse_val = 1'b0;
		endcase
	end

	// Output differs from what we last drove: someone else changed it
	assign mismatch = (state_q == S_RUN) && follow_type && own_q &&
		(res == last_q) && (settle_q == 3'h0) && (obs != last_q);

	// Timer starts over whenever the mismatch clears, so a flicker never restores early
	// Restore applies to every follow-type action
	restore_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.RESTORE_TICKS(RESTORE_TICKS)
	) u_restore (
		.clk(clk),
		.srst(srst),
		.run(mismatch),
		.expired(expired)
	);

	// Decide on a drive command in the running state
	always @* begin
		do_wr = 1'b0;
		wr_val = 1'b0;
		if (state_q == S_RUN) begin
			if (follow_type) begin
				if (!own_q || (res != last_q)) begin
					do_wr = 1'b1;
					wr_val = res;
				end else if (mismatch && expired) begin
					do_wr = 1'b1;
					wr_val = last_q;
				end
			end else if (pulse_type && !fired_q && edge_hit) begin
				do_wr = 1'b1;
				wr_val = pulse_val;
			end
		end
	end

	// Function state
	always @* begin
		state_d = state_q;
		case (state_q)
			S_IDLE, S_ERR: begin
				if (start_req && (act != `ACT_NONE) && (act <= `ACT_XOR))
					state_d = in1_ok ? S_RUN : S_ERR;
			end
			S_RUN: begin
				if (stop_req)
					state_d = S_IDLE;
				else if (restart_evt && run_once)
					state_d = S_IDLE;
				else if (do_wr && run_once)
					state_d = S_DONE;
			end
			S_DONE: begin
				if (stop_req)
					state_d = S_IDLE;
				else if (restart_evt)
					state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
		// A restart reruns a normal-mode function that was running
		if (restart_evt && !run_once && !stop_req && (state_q == S_RUN))
			state_d = in1_ok ? S_RUN : S_ERR;
	end

	// Arming clears edge history and ownership, so the first pass of a follow-type action always drives
	wire arming;
	assign arming = (state_d == S_RUN) &&
		((state_q != S_RUN) || (restart_evt && !run_once));

	always @(posedge clk) begin
		if (srst) begin
			state_q <= S_IDLE;
			error_q <= 1'b0;
			fired_q <= 1'b0;
			own_q <= 1'b0;
			last_q <= 1'b0;
			prev_in1_q <= 1'b0;
			settle_q <= 3'h0;
		end else begin
			state_q <= state_d;
			if (state_d == S_ERR)
				error_q <= 1'b1;
			else if (state_q == S_ERR && state_d != S_ERR)
				error_q <= 1'b0;
			if (arming) begin
				// Edges only count from the start onward
				prev_in1_q <= in1;
				fired_q <= 1'b0;
				own_q <= 1'b0;
				settle_q <= 3'h0;
			end else begin
				prev_in1_q <= in1;
				if (do_wr) begin
					own_q <= 1'b1;
					last_q <= wr_val;
					// Our own change takes a few cycles to show on the input side
					settle_q <= `SETTLE_CYCLES;
					if (pulse_type)
						fired_q <= 1'b1;
				end else if (settle_q != 3'h0) begin
					settle_q <= settle_q - 3'h1;
				end
			end
		end
	end

	// Drive command to the selected programmable output
	always @(posedge clk) begin
		if (srst) begin
			pgm_wr <= 1'b0;
			pgm_wr_idx <= 4'h0;
			pgm_wr_val <= 1'b0;
		end else begin
			// A decision taken while arming saw stale state; the next cycle redoes it
			pgm_wr <= do_wr && !arming;
			if (do_wr) begin
				pgm_wr_idx <= out_idx;
				pgm_wr_val <= wr_val;
			end
		end
	end

	// Writing the refused bit of the status word clears it
	wire refused_clr;
	assign refused_clr = wr && (addr == `REG_STATUS) && wdata[`ST_REFUSED];

	// Configuration: held while running; refused attempts are flagged
	// Settings change only while halted, so a running result never mixes two words
	always @(posedge clk) begin
		if (srst) begin
			cfg_q <= `CFG_RESET;
			refused_q <= 1'b0;
		end else begin
			if (cfg_wr && !busy)
				cfg_q <= wdata[20:0];
			if (cfg_wr && busy)
				refused_q <= 1'b1;
			else if (refused_clr)
				refused_q <= 1'b0;
		end
	end

	// Status word; pending shows a restore delay being counted
	wire [7:0] status;
	assign status[`ST_STATE_MSB:0] = state_q;
	assign status[`ST_ERROR] = error_q;
	assign status[`ST_REFUSED] = refused_q;
	assign status[`ST_OUT_OBS] = obs;
	assign status[`ST_FIRED] = fired_q;
	assign status[`ST_PENDING] = mismatch;

	// Read data stand the cycle after the strobe
	always @(posedge clk) begin
		if (srst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				`REG_CTRL: rdata <= 32'h00000000;
				`REG_CFG: rdata <= {11'h000, cfg_q};
				`REG_STATUS: rdata <= {24'h000000, status};
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule

// *** verification/output_bank.sv ***
module output_bank (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Drive command from the function
	input wire logic pgm_wr,
	input wire logic [3:0] pgm_wr_idx,
	input wire logic pgm_wr_val,
	// Change made by some other party
	input wire logic ext_wr,
	input wire logic [3:0] ext_idx,
	input wire logic ext_val,
	// Present output levels
	output logic [15:0] pgm_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// Outside change wins a clash: the harshest case for the restore logic
	always @(posedge clk) begin
		if (srst)
			pgm_in <= 16'h0000;
		else if (ext_wr)
			pgm_in[ext_idx] <= ext_val;
		else if (pgm_wr)
			pgm_in[pgm_wr_idx] <= pgm_wr_val;
	end
endmodule

// *** verification/logic_fn_asserts.sv ***
module logic_fn_asserts #(
	parameter TICK_CYCLES = 4,
	parameter RESTORE_TICKS = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata,
	// Sources and restart
	input wire logic [15:0] pgm_in,
	input wire logic [15:0] mem_in,
	input wire logic sys_restart,
	// Drive command
	input wire logic pgm_wr,
	input wire logic [3:0] pgm_wr_idx,
	input wire logic pgm_wr_val
);
	timeunit 1ns;
	timeprecision 1ps;
	logic run_q, fired_q, i1, i2, res;
	logic [20:0] cfg_q;
	wire [3:0] act = cfg_q[3:0];
	wire [5:0] s1 = cfg_q[9:4];
	wire [5:0] s2 = cfg_q[15:10];
	wire cont = act == 4'h1 || act == 4'h2 || (act > 4'h6 && act < 4'hc);
	wire start = wr && addr == 8'h00 && wdata[1:0] == 2'b01;
	wire stop = wr && addr == 8'h00 && wdata[1];
	assign i1 = !s1[4] && (s1[5] ? mem_in[s1[3:0]] : pgm_in[s1[3:0]]);
	assign i2 = !s2[4] && (s2[5] ? mem_in[s2[3:0]] : pgm_in[s2[3:0]]);
	always_comb begin
		case (act)
			4'h1: res = i1;
			4'h2: res = !i1;
			4'h7: res = i1 | i2;
			4'h8: res = i1 & i2;
			4'h9: res = !(i1 | i2);
			4'ha: res = !(i1 & i2);
			default: res = i1 ^ i2;
		endcase
	end
	// Shadow of the running state; refused settings never reach it
	always_ff @(posedge clk) begin
		if (srst) begin
			run_q <= 1'b0;
			fired_q <= 1'b0;
			cfg_q <= 21'h010100;
		end else begin
			if (wr && addr == 8'h04 && !run_q)
				cfg_q <= wdata[20:0];
			if (stop)
				run_q <= 1'b0;
			else if (start && act != 4'h0 && act < 4'hc && !s1[4])
				run_q <= 1'b1;
			if (start)
				fired_q <= 1'b0;
			else if (pgm_wr && run_q)
				fired_q <= 1'b1;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (srst);
	sequence drive_s;
		pgm_wr && pgm_wr_val == res && pgm_wr_idx == cfg_q[19:16];
	endsequence
	// Output changed by someone else while the target index stayed put
	sequence outside_chg_s;
		$stable(cfg_q) && $changed(pgm_in[cfg_q[19:16]]) && !$past(pgm_wr);
	endsequence
	read_quiet_a: assert property (!rd |=> rdata == 32'h0)
		else $error("read data outside a read");
	stop_quiet_a: assert property (!run_q && !$past(run_q) |-> !pgm_wr)
		else $error("drive while halted");
	start_drive_a: assert property (start && !run_q && cont && !s1[4] |-> ##2 drive_s)
		else $error("no first drive after start");
	none_quiet_a: assert property (start && act == 4'h0 |=> !pgm_wr [*6])
		else $error("drive with no action");
	result_track_a: assert property (run_q && cont && !cfg_q[20] && $changed(res) |-> ##[2:8] drive_s)
		else $error("result change not driven");
	single_write_a: assert property (fired_q && run_q && (cfg_q[20] || !cont) |-> !pgm_wr)
		else $error("second drive");
	restore_wait_a: assert property (outside_chg_s |-> !pgm_wr [*8])
		else $error("early restore");
	restart_drive_a: assert property (run_q && cont && !cfg_q[20] && $rose(sys_restart) |-> ##[2:8] pgm_wr)
		else $error("no drive after restart");
endmodule

bind logic_fn logic_fn_asserts #(.TICK_CYCLES(TICK_CYCLES), .RESTORE_TICKS(RESTORE_TICKS)) chk (
	.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.pgm_in(pgm_in), .mem_in(mem_in), .sys_restart(sys_restart), .pgm_wr(pgm_wr),
	.pgm_wr_idx(pgm_wr_idx), .pgm_wr_val(pgm_wr_val));

// *** verification/tb_boolean_output_logic_function.sv ***
module tb_boolean_output_logic_function;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, sys_restart = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [15:0] pgm_in, mem_in = 16'h0;
	logic pgm_wr, pgm_wr_val, last_val, x, y, ext_wr = 1'b0, ext_val = 1'b0;
	logic [3:0] pgm_wr_idx, last_idx, oi, ext_idx = 4'h5;
	int bad_count = 0, checked = 0, writes = 0, w0;
	always #5 clk = ~clk;
	logic_fn #(.TICK_CYCLES(4), .RESTORE_TICKS(5)) dut (.clk(clk), .srst(srst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pgm_in(pgm_in), .mem_in(mem_in),
		.sys_restart(sys_restart), .pgm_wr(pgm_wr), .pgm_wr_idx(pgm_wr_idx),
		.pgm_wr_val(pgm_wr_val));
	output_bank bank (.clk(clk), .srst(srst), .pgm_wr(pgm_wr), .pgm_wr_idx(pgm_wr_idx),
		.pgm_wr_val(pgm_wr_val), .ext_wr(ext_wr), .ext_idx(ext_idx), .ext_val(ext_val),
		.pgm_in(pgm_in));
	always @(posedge clk) begin
		if (pgm_wr === 1'b1) begin
			writes <= writes + 1;
			last_val <= pgm_wr_val;
			last_idx <= pgm_wr_idx;
		end
	end
	function automatic logic f(input logic [3:0] a, input logic x, input logic y);
		case (a)
			4'h1: return x;
			4'h2: return !x;
			4'h7: return x | y;
			4'h8: return x & y;
			4'h9: return !(x | y);
			4'ha: return !(x & y);
			4'hb: return x ^ y;
			default: return a[0];
		endcase
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		cyc(1);
		wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rreg(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		cyc(1);
		rd <= 1'b0;
		#1 rv = rdata;
		cyc(1);
	endtask
	task automatic check(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("MISMATCH at %0t: %s", $time, m);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		bad_count++;
		complete_run();
	end
	initial begin
		rv = $urandom(31);
		cyc(5);
		srst <= 1'b0;
		cyc(1);
		rreg(8'h04);
		check(rv === 32'h00010100, "cfg reset");
		rreg(8'h0c);
		check(rv === 32'h0, "unmapped");
		for (int a = 1; a < 12; a++) begin
			oi = 4'($urandom_range(15));
			wreg(8'h04, {12'h000, oi, 6'h22, 6'h21, 4'(a)});
			w0 = writes;
			wreg(8'h00, 32'h1);
			cyc(3);
			for (int k = 0; k < 4; k++) begin
				x = !k[0];
				y = 1'($urandom);
				mem_in <= {13'h0, y, x, 1'b0};
				cyc(12);
				if (a < 3 || a > 6)
					check(last_val === f(4'(a), x, y) && last_idx === oi, "result");
			end
			if (a > 2 && a < 7) begin
				rreg(8'h08);
				check(writes === w0 + 1 && last_val === f(4'(a), x, y), "pulse");
				check(rv[6] === 1'b1, "fired flag");
			end
			wreg(8'h00, 32'h2);
			$display("action %0d done", a);
		end
		mem_in <= 16'h0002;
		wreg(8'h04, 32'h00050021);
		wreg(8'h00, 32'h1);
		cyc(10);
		wreg(8'h04, 32'h0);
		rreg(8'h04);
		check(rv === 32'h00050021, "kept cfg");
		rreg(8'h08);
		check(rv[4] === 1'b1 && rv[2:0] === 3'h1 && rv[5] === 1'b1, "refused");
		w0 = writes;
		ext_wr <= 1'b1;
		cyc(1);
		ext_wr <= 1'b0;
		cyc(16);
		check(writes === w0, "early restore");
		rreg(8'h08);
		check(rv[7] === 1'b1, "pending");
		cyc(30);
		check(writes === w0 + 1 && last_val === 1'b1, "restore");
		sys_restart <= 1'b1;
		cyc(1);
		sys_restart <= 1'b0;
		cyc(10);
		check(writes === w0 + 2, "restart");
		wreg(8'h00, 32'h2);
		$display("restore done");
		wreg(8'h04, 32'h00150021);
		w0 = writes;
		wreg(8'h00, 32'h1);
		cyc(3);
		mem_in <= 16'h0000;
		cyc(12);
		rreg(8'h08);
		check(writes === w0 + 1 && rv[2:0] === 3'h2, "run once");
		wreg(8'h00, 32'h2);
		wreg(8'h04, 32'h00000101);
		wreg(8'h00, 32'h1);
		rreg(8'h08);
		check(rv[3] === 1'b1 && rv[2:0] === 3'h3, "bad input");
		wreg(8'h00, 32'h2);
		wreg(8'h04, 32'h0);
		w0 = writes;
		wreg(8'h00, 32'h1);
		cyc(6);
		check(writes === w0, "none");
		$display("modes done");
		complete_run();
	end
endmodule
